//--- design/serial_instruction_burst_ram_port.sv
// Serial host port: instruction decode, register access and RAM bursts.
// Assumes the host clocks the port (select pin low) and frames with SEL_N.
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Read data FIFO
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   n_q, n_d;
  logic          wr, rd;

  assign in_ready  = (n_q != (AW+1)'(D));
  assign out_valid = (n_q != '0);
  assign out_data  = mem[rp_q];

  always_comb begin
    wr   = in_valid && in_ready;
    rd   = out_valid && out_ready;
    wp_d = wp_q;
    rp_d = rp_q;
    n_d  = n_q;
    if (flush) begin
      wp_d = '0;
      rp_d = '0;
      n_d  = '0;
    end else begin
      if (wr) wp_d = (wp_q == AW'(D-1)) ? '0 : AW'(wp_q + 1'b1);
      if (rd) rp_d = (rp_q == AW'(D-1)) ? '0 : AW'(rp_q + 1'b1);
      if (wr && !rd) n_d = (AW+1)'(n_q + 1'b1);
      else if (rd && !wr) n_d = (AW+1)'(n_q - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      n_q  <= '0;
    end else if (ce) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      n_q  <= n_d;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && wr && !flush) mem[wp_q] <= in_data;
  end
endmodule : byte_fifo

// ==========================================================
// Port top
// How it works
// - Select pin low: host drives serial clock
// - Sample on rising edge, launch on falling
// - Eight-bit instruction opens every cycle
// - Bit 7 high writes, low reads
// - Bits 6:5 give one to four bytes
// - Bit 4 picks RAM byte order
// - Bits 3:2 pick register; 11 means RAM
// - Bits 1:0 give starting register byte
// - Codes 0000/0001 hit control register bytes
// - 01xx and 10xx hit channel configs
// - 1100 result RAM, 1101 offset RAM
// - 1110 and 1111 full-scale RAMs
// - Result RAM never written by host
// - RAMs only accessed as whole bursts
// - Burst follows logical channel order
// - Words equal active channels, bytes RAM width
// - Offset words three bytes, results two
// - Bit order from control register
// - Data follows instruction without another
// - Calibration access halts and resets converter
// - Restart at channel one after calibration
module serial_instruction_burst_ram_port
  import sib_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  // Serial pins
  input  wire logic        CLK_SRC_SEL,
  input  wire logic        SEL_N,
  input  wire logic        SER_CLK,
  input  wire logic        SER_IN,
  output logic             SERIAL_OUT_LINE,
  output logic             SERIAL_OUT_LINE_OE,
  // Result RAM fill from converter
  input  wire logic        RES_WE,
  input  wire logic [2:0]  RES_ADDR,
  input  wire logic [15:0] RES_DATA,
  // Sequencer control
  output logic             CONV_HALT,
  output logic             MOD_RESET,
  output logic             END_OF_SCAN_IRQ_CLEAR,
  output logic             CONV_RESTART,
  // Configuration view
  output logic [15:0]      CHIP_CONTROL_REGISTER,
  output logic [63:0]      CHANNEL_CONFIG_REGISTERS
);
  // ==========================================================
  // Synchronisers
  logic clk_m_q, clk_s_q, clk_p_q, sdi_m_q, sdi_s_q;
  logic sel_m_q, sel_s_q, src_m_q, src_s_q;
  logic rise, fall;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      {clk_m_q, clk_s_q, clk_p_q} <= 3'h0;
      {sdi_m_q, sdi_s_q}          <= 2'h0;
      {sel_m_q, sel_s_q}          <= 2'h3;
      {src_m_q, src_s_q}          <= 2'h0;
    end else if (CE) begin
      clk_m_q <= SER_CLK;
      clk_s_q <= clk_m_q;
      clk_p_q <= clk_s_q;
      sdi_m_q <= SER_IN;
      sdi_s_q <= sdi_m_q;
      sel_m_q <= SEL_N;
      sel_s_q <= sel_m_q;
      src_m_q <= CLK_SRC_SEL;
      src_s_q <= src_m_q;
    end
  end

  assign rise = clk_s_q & ~clk_p_q;
  assign fall = ~clk_s_q & clk_p_q;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] shin_f(logic [7:0] s, logic b, logic m);
    return m ? {s[6:0], b} : {b, s[7:1]};
  endfunction : shin_f

  function automatic logic [7:0] shout_f(logic [7:0] s, logic m);
    return m ? {s[6:0], 1'b0} : {1'b0, s[7:1]};
  endfunction : shout_f

  function automatic logic obit_f(logic [7:0] s, logic m);
    return m ? s[7] : s[0];
  endfunction : obit_f

  function automatic logic [7:0] byte_f(logic [31:0] w, logic [1:0] i);
    return w[8*i +: 8];
  endfunction : byte_f

  function automatic logic [1:0] bpw_f(instr_t i);
    return (i.sub == RAM_RES) ? 2'(DATA_BPW) : 2'(CAL_BPW);
  endfunction : bpw_f

  // ==========================================================
  // Storage
  logic [15:0] res_mem [NCH];
  logic [23:0] cal_mem [3][NCH];
  ph_t         ph_q, ph_d;
  instr_t      ir_q, ir_d, ir_new;
  pos_t        pos_q, pos_d, pos_nx;
  logic [2:0]  cnt_q, cnt_d;
  logic [7:0]  sh_q, sh_d, osr_q, osr_d, rx, rd_byte, v;
  logic [5:0]  ser_q, ser_d, prod_q, prod_d;
  logic [15:0] cr_q, cr_d;
  logic [31:0] ccr1_q, ccr1_d, ccr2_q, ccr2_d, ram_word;
  logic        sdo_q, sdo_d, oe_q, oe_d, halt_q, halt_d;
  logic        modrst_q, modrst_d, eos_q, eos_d, rst_q, rst_d;
  logic        msbf, is_ram, push, pop, flush, cal_we, f_rdy, f_vld;
  logic [1:0]  bpw, bidx, cal_idx;
  logic [3:0]  nch;
  logic [2:0]  phys;
  logic [7:0]  f_data;

  // ==========================================================
  // Addressing
  always_comb begin
    msbf    = cr_q[CR_BITORD];
    nch     = {1'b0, cr_q[CR_NCH_LSB +: 3]} + 4'h1;
    is_ram  = (ir_q.tsel == TGT_RAM);
    bpw     = bpw_f(ir_q);
    bidx    = (is_ram && ir_q.rb) ? 2'(bpw - 2'h1 - pos_q.byt)
                                  : pos_q.byt;
    phys    = CHANNEL_CONFIG_REGISTERS[{pos_q.word, 3'h0} +: CCR_PHYS_W];
    cal_idx = 2'(ir_q.sub - 2'h1);
    pos_nx  = pos_q;
    if (is_ram) begin
      if (pos_q.byt == 2'(bpw - 2'h1)) begin
        pos_nx.word = 3'(pos_q.word + 3'h1);
        pos_nx.byt  = 2'h0;
      end else begin
        pos_nx.byt = 2'(pos_q.byt + 2'h1);
      end
    end else if (ir_q.tsel == TGT_CR) begin
      pos_nx.byt = {1'b0, ~pos_q.byt[0]};
    end else begin
      pos_nx.byt = 2'(pos_q.byt + 2'h1);
    end
    if (ir_q.sub == RAM_RES) ram_word = {16'h0000, res_mem[phys]};
    else ram_word = {8'h00, cal_mem[cal_idx][phys]};
    if (ir_q.tsel == TGT_CR) rd_byte = byte_f({16'h0000, cr_q}, bidx);
    else if (ir_q.tsel == TGT_CCR1) rd_byte = byte_f(ccr1_q, bidx);
    else if (ir_q.tsel == TGT_CCR2) rd_byte = byte_f(ccr2_q, bidx);
    else rd_byte = byte_f(ram_word, bidx);
  end

  // ==========================================================
  // Protocol engine
  always_comb begin
    ph_d = ph_q;  cnt_d = cnt_q;  sh_d = sh_q;  osr_d = osr_q;
    sdo_d = sdo_q;  ir_d = ir_q;  pos_d = pos_q;
    ser_d = ser_q;  prod_d = prod_q;
    cr_d = cr_q;  ccr1_d = ccr1_q;  ccr2_d = ccr2_q;
    halt_d = halt_q;  modrst_d = 1'b0;  eos_d = 1'b0;  rst_d = 1'b0;
    push = 1'b0;  pop = 1'b0;  flush = 1'b0;  cal_we = 1'b0;  v = 8'h00;
    rx     = shin_f(sh_q, sdi_s_q, msbf);
    ir_new = instr_t'(rx);
    if (sel_s_q || src_s_q) begin
      ph_d  = PH_IDLE;
      cnt_d = 3'h0;
      sdo_d = 1'b0;
      flush = 1'b1;
      if (halt_q) begin
        halt_d = 1'b0;
        rst_d  = 1'b1;
      end
    end else begin
      case (ph_q)
        PH_IDLE: ph_d = PH_INSTR;
        PH_INSTR: begin
          if (rise) begin
            sh_d  = rx;
            cnt_d = 3'(cnt_q + 3'h1);
            if (cnt_q == 3'h7) begin
              ir_d  = ir_new;
              ph_d  = PH_XFER;
              pos_d.word = 3'h0;
              pos_d.byt  = (ir_new.tsel == TGT_RAM) ? 2'h0
                                                    : ir_new.sub;
              if (ir_new.tsel == TGT_RAM)
                ser_d = 6'(nch * bpw_f(ir_new));
              else
                ser_d = 6'(ir_new.nb) + 6'h01;
              prod_d = ir_new.wr ? 6'h00 : ser_d;
              if (ir_new.tsel == TGT_RAM && ir_new.sub != RAM_RES) begin
                halt_d   = 1'b1;
                modrst_d = 1'b1;
                eos_d    = 1'b1;
              end
            end
          end
        end
        PH_XFER: begin
          if (rise) begin
            sh_d  = rx;
            cnt_d = 3'(cnt_q + 3'h1);
            if (cnt_q == 3'h7) begin
              if (ir_q.wr) begin
                pos_d = pos_nx;
                if (ir_q.tsel == TGT_CR)
                  cr_d[8*bidx[0] +: 8] = rx;
                else if (ir_q.tsel == TGT_CCR1)
                  ccr1_d[8*bidx +: 8] = rx;
                else if (ir_q.tsel == TGT_CCR2)
                  ccr2_d[8*bidx +: 8] = rx;
                else if (ir_q.sub != RAM_RES)
                  cal_we = 1'b1;
              end
              ser_d = 6'(ser_q - 6'h01);
              if (ser_q == 6'h01) begin
                ph_d  = PH_INSTR;
                flush = 1'b1;
                if (halt_q) begin
                  halt_d = 1'b0;
                  rst_d  = 1'b1;
                end
              end
            end
          end
          if (!ir_q.wr && prod_q != 6'h00 && f_rdy) begin
            push   = 1'b1;
            pos_d  = pos_nx;
            prod_d = 6'(prod_q - 6'h01);
          end
          if (fall && !ir_q.wr) begin
            if (cnt_q == 3'h0) begin
              pop   = f_vld;
              v     = f_vld ? f_data : 8'h00;
              sdo_d = obit_f(v, msbf);
              osr_d = shout_f(v, msbf);
            end else begin
              sdo_d = obit_f(osr_q, msbf);
              osr_d = shout_f(osr_q, msbf);
            end
          end
        end
        default: ph_d = PH_IDLE;
      endcase
    end
    oe_d = (ph_d == PH_XFER) && !ir_d.wr;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ph_q <= PH_IDLE;  cnt_q <= 3'h0;  sh_q <= 8'h00;  osr_q <= 8'h00;
      sdo_q <= 1'b0;  oe_q <= 1'b0;  ir_q <= '0;  pos_q <= '0;
      ser_q <= 6'h00;  prod_q <= 6'h00;
      cr_q <= CR_RST;  ccr1_q <= CCR1_RST;  ccr2_q <= CCR2_RST;
      halt_q <= 1'b0;  modrst_q <= 1'b0;  eos_q <= 1'b0;  rst_q <= 1'b0;
    end else if (CE) begin
      ph_q <= ph_d;  cnt_q <= cnt_d;  sh_q <= sh_d;  osr_q <= osr_d;
      sdo_q <= sdo_d;  oe_q <= oe_d;  ir_q <= ir_d;  pos_q <= pos_d;
      ser_q <= ser_d;  prod_q <= prod_d;
      cr_q <= cr_d;  ccr1_q <= ccr1_d;  ccr2_q <= ccr2_d;
      halt_q <= halt_d;  modrst_q <= modrst_d;  eos_q <= eos_d;
      rst_q <= rst_d;
    end
  end

  // ==========================================================
  // RAM arrays
  always_ff @(posedge REF_CLK) begin
    if (CE && RES_WE) res_mem[RES_ADDR] <= RES_DATA;
    if (CE && cal_we) cal_mem[cal_idx][phys][8*bidx +: 8] <= rx;
  end

  byte_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk       (REF_CLK),
    .rst       (RST),
    .ce        (CE),
    .flush     (flush),
    .in_valid  (push),
    .in_ready  (f_rdy),
    .in_data   (rd_byte),
    .out_valid (f_vld),
    .out_ready (pop),
    .out_data  (f_data)
  );

  // ==========================================================
  // Outputs
  assign SERIAL_OUT_LINE          = sdo_q;
  assign SERIAL_OUT_LINE_OE       = oe_q;
  assign CONV_HALT                = halt_q;
  assign MOD_RESET                = modrst_q;
  assign END_OF_SCAN_IRQ_CLEAR    = eos_q;
  assign CONV_RESTART             = rst_q;
  assign CHIP_CONTROL_REGISTER    = cr_q;
  assign CHANNEL_CONFIG_REGISTERS = {ccr2_q, ccr1_q};
endmodule : serial_instruction_burst_ram_port

`default_nettype wire

//--- design/sib_pkg.sv
// Shared constants and types for the serial instruction and burst RAM port.
// Assumes a single reference clock domain; serial pins arrive unsynchronised.
package sib_pkg;
  // ==========================================================
  // Geometry
  localparam int NCH       = 8;
  localparam int DATA_BPW  = 2;
  localparam int CAL_BPW   = 3;
  localparam int FIFO_W    = 8;
  localparam int FIFO_D    = 32;
  // ==========================================================
  // Instruction target codes
  localparam logic [1:0] TGT_CR   = 2'h0;
  localparam logic [1:0] TGT_CCR1 = 2'h1;
  localparam logic [1:0] TGT_CCR2 = 2'h2;
  localparam logic [1:0] TGT_RAM  = 2'h3;
  localparam logic [1:0] RAM_RES  = 2'h0;
  localparam logic [1:0] RAM_OFS  = 2'h1;
  localparam logic [1:0] RAM_PFS  = 2'h2;
  localparam logic [1:0] RAM_NFS  = 2'h3;
  // ==========================================================
  // Control and channel config register fields and reset values
  localparam int CR_BITORD   = 1;
  localparam int CR_NCH_LSB  = 5;
  localparam int CCR_PHYS_W  = 3;
  localparam logic [15:0] CR_RST   = 16'h0000;
  localparam logic [31:0] CCR1_RST = 32'h0302_0100;
  localparam logic [31:0] CCR2_RST = 32'h0706_0504;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {PH_IDLE, PH_INSTR, PH_XFER} ph_t;
  typedef struct packed {
    logic       wr;
    logic [1:0] nb;
    logic       rb;
    logic [1:0] tsel;
    logic [1:0] sub;
  } instr_t;
  typedef struct packed {
    logic [2:0] word;
    logic [1:0] byt;
  } pos_t;
endpackage : sib_pkg

//--- dv/sib_monitor.sv
// Port-level checker for the serial instruction and burst RAM port.
// Assumes one REF_CLK domain; bound to the top by the statement below.
`timescale 1ns/100ps
`default_nettype none
module sib_monitor (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        CE,
  // Serial pins
  input wire logic        CLK_SRC_SEL,
  input wire logic        SEL_N,
  input wire logic        SER_CLK,
  input wire logic        SERIAL_OUT_LINE,
  input wire logic        SERIAL_OUT_LINE_OE,
  // Sequencer and registers
  input wire logic        CONV_HALT,
  input wire logic        MOD_RESET,
  input wire logic        END_OF_SCAN_IRQ_CLEAR,
  input wire logic        CONV_RESTART,
  input wire logic [15:0] CHIP_CONTROL_REGISTER,
  input wire logic [63:0] CHANNEL_CONFIG_REGISTERS
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ==========================================================
  // Assertions
  AST_SRC_IDLE: assert property (
    (CE && CLK_SRC_SEL)[*5] |=> !SERIAL_OUT_LINE_OE)
    else $error("port drives with clock select high");
  AST_LAUNCH_FALL: assert property (
    $changed(SERIAL_OUT_LINE) && SERIAL_OUT_LINE_OE |-> !$past(SER_CLK, 2))
    else $error("read bit launched outside clock low");
  AST_OE_AFTER_RISE: assert property (
    $rose(SERIAL_OUT_LINE_OE) |-> $past(SER_CLK, 2) && !SEL_N)
    else $error("read phase opened off a rising edge");
  AST_CAL_START: assert property (
    $rose(CONV_HALT) |-> MOD_RESET && END_OF_SCAN_IRQ_CLEAR
      && $past(SER_CLK, 2))
    else $error("halt without modulator reset and clear");
  AST_RESET_PULSE: assert property (
    MOD_RESET |=> !MOD_RESET && CONV_HALT)
    else $error("modulator reset not a single pulse");
  AST_RESTART: assert property (
    $fell(CONV_HALT) && !$past(RST) |-> CONV_RESTART && !MOD_RESET)
    else $error("halt released without restart");
  AST_RESTART_ONLY: assert property (
    CONV_RESTART |-> !CONV_HALT && $past(CONV_HALT))
    else $error("restart without preceding halt");
  AST_REG_HOLD: assert property (
    CONV_HALT |=> $stable(CHIP_CONTROL_REGISTER)
      && $stable(CHANNEL_CONFIG_REGISTERS))
    else $error("registers changed during calibration burst");
  AST_REG_WRITE: assert property (
    ($changed(CHIP_CONTROL_REGISTER) || $changed(CHANNEL_CONFIG_REGISTERS))
      && !$past(RST) |-> !SERIAL_OUT_LINE_OE && $past(SER_CLK, 2))
    else $error("register changed outside a write");
  cover property (MOD_RESET);
  cover property ($rose(SERIAL_OUT_LINE_OE));
  cover property (CONV_RESTART);
endmodule : sib_monitor

bind serial_instruction_burst_ram_port sib_monitor i_sib_monitor (
  .REF_CLK, .RST, .CE, .CLK_SRC_SEL, .SEL_N, .SER_CLK, .SERIAL_OUT_LINE,
  .SERIAL_OUT_LINE_OE, .CONV_HALT, .MOD_RESET, .END_OF_SCAN_IRQ_CLEAR,
  .CONV_RESTART, .CHIP_CONTROL_REGISTER, .CHANNEL_CONFIG_REGISTERS);
`default_nettype wire

//--- dv/host_model.sv
// Host serial master: frames, clocks and shifts bytes with a 200 ns bit period.
// Assumes clock select low; clock stalls low between bytes.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Serial pins
  output var logic SEL_N,
  output var logic SER_CLK,
  output var logic SER_IN,
  input wire logic SERIAL_OUT_LINE
);
  logic msb_first;
  initial begin
    SEL_N = 1'b1;
    SER_CLK = 1'b0;
    SER_IN = 1'b0;
    msb_first = 1'b0;
  end
  // ==========================================================
  // Frame and byte transfer
  task automatic frame(input logic on);
    #200;
    SEL_N = !on;
    #400;
  endtask : frame
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    int k;
    for (int i = 0; i < 8; i++) begin
      k = msb_first ? 7 - i : i;
      SER_IN = tx[k];
      #100 rx[k] = SERIAL_OUT_LINE;
      SER_CLK = 1'b1;
      #100 SER_CLK = 1'b0;
    end
  endtask : xfer
endmodule : host_model
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the serial instruction and burst RAM port.
// Assumes the host model above and 40 MHz REF_CLK.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sib_pkg::*;
  logic REF_CLK, RST, CE, CLK_SRC_SEL, RES_WE;
  logic [2:0] RES_ADDR;
  logic [15:0] RES_DATA;
  wire logic SEL_N, SER_CLK, SER_IN, SERIAL_OUT_LINE, SERIAL_OUT_LINE_OE;
  wire logic CONV_HALT, MOD_RESET, END_OF_SCAN_IRQ_CLEAR, CONV_RESTART;
  wire logic [15:0] CHIP_CONTROL_REGISTER;
  wire logic [63:0] CHANNEL_CONFIG_REGISTERS;
  wire logic sdo_line;
  int n_mismatch, cmp_count, n_mod, n_rst, cyc;
  logic [7:0] rx;
  serial_instruction_burst_ram_port i_serial_instruction_burst_ram_port (
    .REF_CLK                  (REF_CLK),
    .RST                      (RST),
    .CE                       (CE),
    .CLK_SRC_SEL              (CLK_SRC_SEL),
    .SEL_N                    (SEL_N),
    .SER_CLK                  (SER_CLK),
    .SER_IN                   (SER_IN),
    .SERIAL_OUT_LINE          (SERIAL_OUT_LINE),
    .SERIAL_OUT_LINE_OE       (SERIAL_OUT_LINE_OE),
    .RES_WE                   (RES_WE),
    .RES_ADDR                 (RES_ADDR),
    .RES_DATA                 (RES_DATA),
    .CONV_HALT                (CONV_HALT),
    .MOD_RESET                (MOD_RESET),
    .END_OF_SCAN_IRQ_CLEAR    (END_OF_SCAN_IRQ_CLEAR),
    .CONV_RESTART             (CONV_RESTART),
    .CHIP_CONTROL_REGISTER    (CHIP_CONTROL_REGISTER),
    .CHANNEL_CONFIG_REGISTERS (CHANNEL_CONFIG_REGISTERS)
  );
  host_model i_host_model (
    .SEL_N           (SEL_N),
    .SER_CLK         (SER_CLK),
    .SER_IN          (SER_IN),
    .SERIAL_OUT_LINE (sdo_line)
  );
  // Released read line shows the inverse of its last bit
  assign sdo_line = SERIAL_OUT_LINE_OE ? SERIAL_OUT_LINE : ~SERIAL_OUT_LINE;
  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    cyc++;
    if (MOD_RESET === 1'b1) n_mod++;
    if (CONV_RESTART === 1'b1) n_rst++;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic give_verdict;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [63:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) i_host_model.xfer(q[i], rx);
  endtask : send
  task automatic rd(input string nm, input logic [7:0] q[$]);
    foreach (q[i]) begin
      i_host_model.xfer(8'h00, rx);
      chk(nm, q[i], rx);
    end
  endtask : rd
  task automatic regs(input logic [15:0] c);
    chk("cr", c, CHIP_CONTROL_REGISTER);
    chk("ccr", 64'h0705_0504_0103_0207, CHANNEL_CONFIG_REGISTERS);
  endtask : regs
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    chk("ccr rst", {CCR2_RST, CCR1_RST}, CHANNEL_CONFIG_REGISTERS);
    i_host_model.frame(1);
    send('{8'hA1, 8'h00, 8'h42});
    i_host_model.msb_first = 1'b1;
    send('{8'hE7, 8'h01, 8'h07, 8'h02, 8'h03, 8'h8A, 8'h05});
    send('{8'h25});
    rd("ccr read", '{8'h02, 8'h03});
    i_host_model.frame(0);
    regs(16'h0042);
  endtask : t_regs
  task automatic t_results;
    for (int k = 0; k < 8; k++) begin
      @(posedge REF_CLK) #2;
      RES_WE = 1'b1;
      RES_ADDR = 3'(k);
      RES_DATA = 16'h1020 + 16'(k) * 16'h0101;
    end
    @(posedge REF_CLK) #2;
    RES_WE = 1'b0;
    i_host_model.frame(1);
    send('{8'h1C});
    rd("res", '{8'h17, 8'h27, 8'h12, 8'h22, 8'h13, 8'h23});
    send('{8'hEC, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55});
    send('{8'h0C});
    rd("res lsb", '{8'h27, 8'h17, 8'h22, 8'h12, 8'h23, 8'h13});
    i_host_model.frame(0);
  endtask : t_results
  task automatic t_cal;
    logic [7:0] wq[$], eq[$];
    int m, r;
    for (int c = 1; c < 4; c++) begin
      wq = {};
      eq = {};
      for (int i = 0; i < 9; i++) begin
        wq.push_back(8'(c * 16 + i));
        eq.push_back(8'(c * 16 + (i / 3) * 3 + 2 - i % 3));
      end
      m = n_mod;
      r = n_rst;
      i_host_model.frame(1);
      send('{8'hAC | 8'(c)});
      #200 chk("halt", 1, CONV_HALT);
      send(wq);
      #300 chk("run", 0, CONV_HALT);
      send('{8'h1C | 8'(c)});
      rd("cal", eq);
      i_host_model.frame(0);
      chk("modrst", 2, n_mod - m);
      chk("restart", 2, n_rst - r);
      regs(16'h0042);
    end
  endtask : t_cal
  task automatic t_abort;
    r_abort: begin
      int r;
      r = n_rst;
      i_host_model.frame(1);
      send('{8'hAD, 8'h11, 8'h22});
      i_host_model.frame(0);
      chk("abort halt", 0, CONV_HALT);
      chk("abort restart", 1, n_rst - r);
      @(posedge REF_CLK) #2;
      CLK_SRC_SEL = 1'b1;
      i_host_model.frame(1);
      send('{8'h80, 8'hFF});
      i_host_model.frame(0);
      regs(16'h0042);
      @(posedge REF_CLK) #2;
      CLK_SRC_SEL = 1'b0;
      i_host_model.frame(1);
      send('{8'h00});
      rd("cr b0", '{8'h42});
      i_host_model.frame(0);
    end
  endtask : t_abort
  task automatic t_freeze;
    @(posedge REF_CLK) #2;
    CE = 1'b0;
    i_host_model.frame(1);
    send('{8'h80, 8'hFF});
    i_host_model.frame(0);
    regs(16'h0042);
    @(posedge REF_CLK) #2;
    CE = 1'b1;
    i_host_model.frame(1);
    send('{8'h00});
    rd("cr thaw", '{8'h42});
    i_host_model.frame(0);
  endtask : t_freeze
  // ==========================================================
  // Main sequence
  initial begin
    RST = 1'b1;
    CE = 1'b1;
    CLK_SRC_SEL = 1'b0;
    RES_WE = 1'b0;
    RES_ADDR = 3'h0;
    RES_DATA = 16'h0000;
    repeat (12) @(posedge REF_CLK);
    #2 RST = 1'b0;
    repeat (4) @(posedge REF_CLK);
    #2 chk("cr rst", CR_RST, CHIP_CONTROL_REGISTER);
    t_regs();
    t_results();
    t_cal();
    t_abort();
    t_freeze();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
